// File: src/acs_pkg.sv
// Constants shared by the converter sequencing block.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package acs_pkg;
    localparam int          CLK_MHZ        = 100;
    // Bus addresses on the two-wire link
    localparam logic [6:0]  GLOBAL_ADDR    = 7'h77;
    localparam logic [6:0]  OWN_ADDR_LO    = 7'h14;
    localparam logic [6:0]  OWN_ADDR_HI    = 7'h54;
    // Timing: reference settling and conversion periods
    localparam int          REF_SETTLE_US  = 12000;
    localparam int          REF_SETTLE_CYC = REF_SETTLE_US * CLK_MHZ;
    localparam int          CONV60_US      = 16667;
    localparam int          CONV60_CYC     = CONV60_US * CLK_MHZ;
    localparam int          CONV30_US      = 33333;
    localparam int          CONV30_CYC     = CONV30_US * CLK_MHZ;
    // Register offsets
    localparam logic [7:0]  REG_SAMPLE     = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_RESULT     = 8'h08;
    // Reset values
    localparam logic [15:0] SAMPLE_RST     = 16'h0000;
    localparam logic        RATE_RST       = 1'b0;
    localparam logic        SLEEP_RST      = 1'b0;
    // Configuration byte fields
    localparam int          CFG_PROG_ONE   = 7;
    localparam int          CFG_PROG_TWO   = 6;
    localparam int          CFG_RATE       = 5;
    localparam int          CFG_SLEEP      = 4;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    typedef enum logic [0:0] {CV_RUN = 1'b0, CV_DONE = 1'b1} acs_conv_t;
    typedef enum logic [2:0] {
        I_IDLE = 3'b000, I_ADDR = 3'b001, I_AACK = 3'b010, I_READ = 3'b011,
        I_WRITE = 3'b100, I_WACK = 3'b101, I_WAIT = 3'b110
    } acs_i2c_t;
endpackage

// File: src/acs_link_if.sv
// Link between the two-wire slave and the conversion core.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface acs_link_if;
    logic        conv_busy;
    logic [15:0] result;
    logic        addr_ack;
    logic        read_done;
    logic        xfer_stop;
    logic        cfg_load;
    logic        rate_new;
    logic        sleep_new;
    modport slave (input conv_busy, result,
                   output addr_ack, read_done, xfer_stop, cfg_load, rate_new, sleep_new);
    modport core  (output conv_busy, result,
                   input addr_ack, read_done, xfer_stop, cfg_load, rate_new, sleep_new);
endinterface

// File: src/acs_i2c_slave.sv
// Two-wire bus slave: address match, result read-out, config write.
// Assumes pins are asynchronous to clk_sys; SDA is open drain.
`timescale 1ns/1ns
module acs_i2c_slave
    import acs_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic address_select_pin,
    acs_link_if.slave lk
);
    logic [1:0]  scl_s, sda_s, asel_s;
    logic        scl_q, sda_q, sel, rd, wr_got, sda_low;
    logic [7:0]  sh, cfg_byte;
    logic [15:0] out_sh;
    logic [4:0]  cnt;
    acs_i2c_t    st;

    // Edge and condition decode from synchronised pins
    wire scl_rise  = scl_s[1] & ~scl_q;
    wire scl_fall  = ~scl_s[1] & scl_q;
    wire start_c   = scl_s[1] & scl_q & sda_q & ~sda_s[1];
    wire stop_c    = scl_s[1] & scl_q & ~sda_q & sda_s[1];
    wire [6:0] own = asel_s[1] ? OWN_ADDR_HI : OWN_ADDR_LO;
    wire glob_hit  = (sh[7:1] == GLOBAL_ADDR) & ~sh[0];
    wire addr_hit  = ((sh[7:1] == own) | glob_hit) & ~lk.conv_busy;
    wire byte_end  = scl_fall & (cnt == 5'd8);

    assign sda_out      = 1'b0;
    assign sda_oe       = sda_low;
    assign lk.xfer_stop = stop_c & sel;
    assign lk.cfg_load  = stop_c & sel & wr_got
                          & cfg_byte[CFG_PROG_ONE] & ~cfg_byte[CFG_PROG_TWO];
    assign lk.rate_new  = cfg_byte[CFG_RATE];
    assign lk.sleep_new = cfg_byte[CFG_SLEEP];

    // Two-stage synchronisers, then one delay for edge detection
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s  <= 2'h3;
            sda_s  <= 2'h3;
            asel_s <= 2'h0;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
        end
        else
        begin
            scl_s  <= {scl_s[0], scl_in};
            sda_s  <= {sda_s[0], sda_in};
            asel_s <= {asel_s[0], address_select_pin};
            scl_q  <= scl_s[1];
            sda_q  <= sda_s[1];
        end
    end

    // Transfer sequencer
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= I_IDLE; sh <= 8'h00; cfg_byte <= 8'h00; out_sh <= 16'h0000;
            cnt <= 5'd0; sel <= 1'b0; rd <= 1'b0; wr_got <= 1'b0; sda_low <= 1'b0;
            lk.addr_ack <= 1'b0; lk.read_done <= 1'b0;
        end
        else
        begin
            lk.addr_ack  <= 1'b0;
            lk.read_done <= 1'b0;
            if (start_c)
            begin
                st <= I_ADDR; cnt <= 5'd0; sel <= 1'b0; wr_got <= 1'b0; sda_low <= 1'b0;
            end
            else if (stop_c)
            begin
                st <= I_IDLE; sel <= 1'b0; sda_low <= 1'b0;
            end
            else
            begin
                case (st)
                    I_ADDR, I_WRITE:
                    begin
                        if (scl_rise)
                        begin
                            sh  <= {sh[6:0], sda_s[1]};
                            cnt <= cnt + 5'd1;
                        end
                        if (byte_end && st == I_WRITE)
                        begin
                            cfg_byte <= sh; wr_got <= 1'b1; sda_low <= 1'b1; st <= I_WACK;
                        end
                        else if (byte_end && addr_hit)
                        begin
                            sda_low <= 1'b1; sel <= 1'b1; rd <= sh[0]; st <= I_AACK;
                            lk.addr_ack <= 1'b1;
                        end
                        else if (byte_end)
                            st <= I_WAIT;
                    end
                    I_AACK:
                    begin
                        if (scl_fall)
                        begin
                            cnt <= 5'd0;
                            out_sh <= lk.result;
                            sda_low <= rd & ~lk.result[15];
                            st <= rd ? I_READ : I_WRITE;
                        end
                    end
                    I_READ:
                    begin
                        if (scl_fall && cnt == 5'd15)
                        begin
                            sda_low <= 1'b0; lk.read_done <= 1'b1; st <= I_WAIT;
                        end
                        else if (scl_fall)
                        begin
                            cnt <= cnt + 5'd1; out_sh <= out_sh << 1; sda_low <= ~out_sh[14];
                        end
                    end
                    I_WACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_low <= 1'b0; st <= I_WAIT;
                        end
                    end
                    default: st <= st;
                endcase
            end
        end
    end
endmodule

// File: src/acs_ref_ctrl.sv
// Reference power sequencer with start-up settling timer.
// Assumes one-cycle event pulses on clk_sys.
`timescale 1ns/1ns
module acs_ref_ctrl #(
    parameter int SETTLE_CYC = acs_pkg::REF_SETTLE_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic conv_end,
    input  wire logic sleep_bit,
    input  wire logic wake,
    output logic      ref_on,
    output logic      ref_settled
);
    logic [21:0] settle_cnt;

    assign ref_settled = ref_on && (settle_cnt == 22'(SETTLE_CYC));

    // Power state and settling count; wake wins over sleep
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_on     <= 1'b1;
            settle_cnt <= 22'd0;
        end
        else if (wake && !ref_on)
        begin
            ref_on     <= 1'b1;
            settle_cnt <= 22'd0;
        end
        else if (conv_end && sleep_bit && !wake)
            ref_on <= 1'b0;
        else if (ref_on && !ref_settled)
            settle_cnt <= settle_cnt + 22'd1;
    end
endmodule

// File: src/acs_top.sv
// Conversion sequencing and reference power control of a two-wire slave
// converter, with an AXI4-Lite window for the analog stand-in and status.
// Assumes a 100 MHz clk_sys, asynchronous active-low reset, open-drain SDA.
//
// Functional notes
// - Broadcast address 1110111 with write bit
// - Broadcast write when idle is acknowledged
// - Optional config byte after broadcast accepted
// - Stop applies config, starts new conversion
// - Stop without byte keeps config, converts
// - Sleep set: reference off after next conversion
// - Last conversion before sleep stays valid
// - Address acknowledge powers reference back up
// - Reference needs 12ms settling after power
// - Reading all 16 bits starts conversion
// - Sleep clear keeps reference always powered
// - Own address 0010100 or 1010100 by pin
// - Addressed while converting gives not-acknowledge
// - Config applies only when enables are 1,0
// - Rate bit: 0 is 60Hz, 1 is 30Hz
`timescale 1ns/1ns
module acs_top
    import acs_pkg::*;
#(
    parameter int CONV60     = acs_pkg::CONV60_CYC,
    parameter int CONV30     = acs_pkg::CONV30_CYC,
    parameter int SETTLE     = acs_pkg::REF_SETTLE_CYC,
    parameter bit SINGLE_END = 1'b1
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        address_select_pin,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import acs_pkg::*;

    // ------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------
    acs_link_if  lk ();
    acs_conv_t   conv_st;
    logic [21:0] conv_cnt;
    logic [15:0] sample;
    logic [15:0] result;
    logic        result_valid;
    logic        run_valid;
    logic        rate;
    logic        sleep;
    logic        ref_on;
    logic        ref_settled;
    logic        conv_end;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    acs_i2c_slave u_i2c (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .scl_in             (scl_in),
        .sda_in             (sda_in),
        .sda_out            (sda_out),
        .sda_oe             (sda_oe),
        .address_select_pin (address_select_pin),
        .lk                 (lk.slave)
    );

    acs_ref_ctrl #(.SETTLE_CYC(SETTLE)) u_ref (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .conv_end    (conv_end),
        .sleep_bit   (sleep),
        .wake        (lk.addr_ack),
        .ref_on      (ref_on),
        .ref_settled (ref_settled)
    );

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    // Period select; the rate bit only matters on single-ended parts
    wire        slow_rate  = rate & SINGLE_END;
    wire [21:0] conv_last  = slow_rate ? 22'(CONV30 - 1) : 22'(CONV60 - 1);
    assign      conv_end   = (conv_st == CV_RUN) && (conv_cnt == conv_last);
    wire        start_conv = (conv_st == CV_DONE) && (lk.read_done || lk.xfer_stop);

    assign lk.conv_busy = (conv_st == CV_RUN);
    assign lk.result    = result;

    // Conversion timer; powered up straight into a conversion
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_st  <= CV_RUN;
            conv_cnt <= 22'd0;
        end
        else if (conv_end)
            conv_st <= CV_DONE;
        else if (start_conv)
        begin
            conv_st  <= CV_RUN;
            conv_cnt <= 22'd0;
        end
        else if (conv_st == CV_RUN)
            conv_cnt <= conv_cnt + 22'd1;
    end

    // Result capture; valid only if the reference was settled throughout
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result       <= 16'h0000;
            result_valid <= 1'b0;
            run_valid    <= 1'b0;
        end
        else if (start_conv)
            run_valid <= ref_settled;
        else if (conv_end)
        begin
            result       <= sample;
            result_valid <= run_valid & ref_settled;
        end
        else if (conv_st == CV_RUN && !ref_settled)
            run_valid <= 1'b0;
    end

    // Configuration applied at the stop of a programming write
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate  <= RATE_RST;
            sleep <= SLEEP_RST;
        end
        else if (lk.cfg_load)
        begin
            rate  <= lk.rate_new;
            sleep <= lk.sleep_new;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data may arrive in either order; respond when both held
    wire        do_write  = aw_got && w_got && !s_axi_bvalid;
    wire        wr_sample = (aw_addr == REG_SAMPLE);
    wire        rd_sample = (s_axi_araddr == REG_SAMPLE);
    wire        rd_status = (s_axi_araddr == REG_STATUS);
    wire        rd_result = (s_axi_araddr == REG_RESULT);
    wire [31:0] status_w  = {26'h0, sleep, slow_rate, result_valid,
                             ref_settled, ref_on, lk.conv_busy};
    wire        rd_hit    = rd_sample || rd_status || rd_result;
    wire [31:0] rd_word   = rd_sample ? {16'h0, sample} :
                            rd_status ? status_w :
                            rd_result ? {16'h0, result} : 32'h0;

    assign s_axi_awready = !aw_got;
    assign s_axi_wready  = !w_got;
    assign s_axi_arready = !s_axi_rvalid;

    // Write address and data holding
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_got <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_got <= 1'b0;
        end
    end

    // Sample register and write response
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample       <= SAMPLE_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_sample ? RESP_OKAY : RESP_SLVERR;
            if (wr_sample && w_strb[0])
                sample[7:0] <= w_data[7:0];
            if (wr_sample && w_strb[1])
                sample[15:8] <= w_data[15:8];
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read response
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Full read-out restarts the converter next cycle
    read_restart_a: assert property (
        (lk.read_done && conv_st == CV_DONE) |=> lk.conv_busy && conv_cnt == 22'd0)
        else $error("conversion did not restart after full read");

    // Selected stop starts a conversion
    stop_restart_a: assert property (
        (lk.xfer_stop && conv_st == CV_DONE) |=> conv_st == CV_RUN)
        else $error("stop did not start a conversion");

    // Stop without programming leaves configuration alone
    cfg_keep_a: assert property (
        (lk.xfer_stop && !lk.cfg_load) |=> $stable(rate) && $stable(sleep))
        else $error("configuration changed without programming");

    // Programming write loads the received bits
    cfg_apply_a: assert property (
        lk.cfg_load |=> rate == $past(lk.rate_new) && sleep == $past(lk.sleep_new))
        else $error("configuration not applied");

    // Sleep turns the reference off right after the conversion
    sleep_off_a: assert property (
        (conv_end && sleep && !lk.addr_ack) |=> !ref_on ##1 (!ref_on || $past(lk.addr_ack)))
        else $error("reference not powered down after conversion");

    // Reference stays up during a conversion
    run_power_a: assert property (
        (lk.conv_busy && ref_on && !conv_end) |=> ref_on)
        else $error("reference dropped mid conversion");

    // Default sleep keeps the reference on across conversion end
    ref_keep_a: assert property (
        (conv_end && !sleep && ref_on) |=> ref_on [*2])
        else $error("reference dropped with sleep clear");

    // Address acknowledge wakes the reference, unsettled at first
    wake_up_a: assert property (
        (lk.addr_ack && !ref_on) |=> ref_on && !ref_settled)
        else $error("reference not woken by acknowledge");

    // Last conversion before sleep keeps a valid result
    last_valid_a: assert property (
        (conv_end && run_valid && ref_settled) |=> result_valid && result == $past(sample))
        else $error("result before sleep not valid");

    // Busy converter never acknowledges
    busy_nak_a: assert property (
        (lk.conv_busy && !$past(sda_oe)) |-> !lk.addr_ack)
        else $error("acknowledged while converting");

    // Conversion length follows the rate
    conv_len_a: assert property (
        (lk.conv_busy && conv_cnt == conv_last) |=> !lk.conv_busy)
        else $error("conversion length wrong");

    // Programming stop restarts the converter at once
    cfg_start_a: assert property (
        lk.cfg_load |=> lk.conv_busy && conv_cnt == 22'd0)
        else $error("programming stop did not start a conversion");

    // Conversion ending on an unsettled reference is flagged invalid
    unsettled_result_a: assert property (
        (conv_end && !ref_settled) |=> !result_valid)
        else $error("result valid without settled reference");

    // Sleep clear never drops the reference
    ref_hold_a: assert property (
        (!sleep && ref_on) |=> ref_on)
        else $error("reference off while sleep clear");

    sync_cfg_c:   cover property (lk.cfg_load ##1 lk.conv_busy);
    read_cyc_c:   cover property (lk.read_done ##1 lk.conv_busy);
    sleep_wake_c: cover property (!ref_on ##[1:1000] lk.addr_ack ##1 ref_on);
    slow_conv_c:  cover property (slow_rate && conv_end);
endmodule

// File: tb/acs_bus_master.sv
// Two-wire bus master model; data open drain, clock driven directly.
// Assumes a pull-up outside resolves the data wire; clock parks high.
`timescale 1ns/1ns
module acs_bus_master (
    input  wire logic clk_sys,
    input  wire logic sda_pin,
    output logic      scl,
    output logic      sda_pull
);
    // ----------------------------------------
    // Bus idle, frame and bit tasks
    // ----------------------------------------
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Half bit, keeps clock low at least six cycles
    task automatic half();
        repeat (6) @(posedge clk_sys);
    endtask
    // Data moves only while clock is low; sampled at end of high phase
    task automatic bitx(input logic b, output logic r);
        @(posedge clk_sys);
        sda_pull <= !b;
        half();
        scl <= 1'b1;
        half();
        r = sda_pin;
        scl <= 1'b0;
    endtask
    task automatic start();
        @(posedge clk_sys);
        sda_pull <= 1'b1;
        half();
        scl <= 1'b0;
    endtask
    task automatic stop();
        @(posedge clk_sys);
        sda_pull <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b0;
        half();
    endtask
    // Byte msb first, then releases data for the acknowledge
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(v[i], r);
        bitx(1'b1, ack);
    endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench: bus master model on the pins, AXI4-Lite master.
// Assumes shortened conversion and settling counts.
`timescale 1ns/1ns
module tb_top;
    import acs_pkg::*;
    typedef struct {string nm; logic [31:0] m; logic [31:0] e;} acs_note_t;
    // ----------------------------------------
    // Signals, design and partner
    // ----------------------------------------
    logic        clk_sys = 1'b0, rst_n = 1'b0, address_select_pin = 1'b0;
    logic        scl, sda_pull, sda_out, sda_oe;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h3;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    acs_note_t   q[$];
    logic [31:0] obs;
    event        seen;
    int          n_errors = 0;
    int          n_compared = 0;
    wire         sda = !((sda_oe && !sda_out) || sda_pull);  // Pull-up when nobody pulls
    acs_top #(.CONV60(200), .CONV30(400), .SETTLE(100)) u_acs_top (.clk_sys, .rst_n,
        .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .address_select_pin, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    acs_bus_master m_bus (.clk_sys, .sda_pin(sda), .scl, .sda_pull);
    always #5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Notes, comparison and verdict
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] m, e, o);
        q.push_back('{nm, m, e});
        obs = o;
        -> seen;
        #1;
    endtask
    // Oldest note against each result as it shows
    always @(seen)
    begin
        n_compared++;
        if ((obs & q[0].m) !== q[0].e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", q[0].nm, q[0].e, obs & q[0].m);
        end
        void'(q.pop_front());
    end
    task automatic finish_test();
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // AXI4-Lite write; each channel held until its own ready
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        {ad, wd} = 2'b00;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!(ad && wd))
        begin
            @(posedge clk_sys);
            ad = ad || (s_axi_awvalid && s_axi_awready);
            wd = wd || (s_axi_wvalid && s_axi_wready);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end
        do @(posedge clk_sys); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'h3, {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rresp", 32'h3, {30'h0, er}, {30'h0, s_axi_rresp});
        chk("rdata", m, e, s_axi_rdata);
    endtask
    // Start plus address byte, acknowledge level compared
    task automatic addr(input logic [6:0] a, input logic rw, input logic ea);
        logic k;
        m_bus.start();
        m_bus.wbyte({a, rw}, k);
        chk("ack", 32'h1, {31'h0, ea}, {31'h0, k});
    endtask
    task automatic rd16(input logic [15:0] e);
        logic [15:0] d;
        logic r;
        for (int i = 15; i >= 0; i--) m_bus.bitx(1'b1, d[i]);
        m_bus.bitx(1'b1, r);
        chk("data", 32'hffff, {16'h0, e}, {16'h0, d});
    endtask
    // Broadcast call with one config byte once the conversion is over
    task automatic sync(input logic [7:0] c, input logic [31:0] m, e);
        logic k;
        repeat (450) @(posedge clk_sys);
        addr(GLOBAL_ADDR, 1'b0, 1'b0);
        m_bus.wbyte(c, k);
        chk("cfg_ack", 32'h1, 32'h0, {31'h0, k});
        m_bus.stop();
        axr(REG_STATUS, m, e, RESP_OKAY);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        logic [15:0] v;
        v = lfsr(16'h99cc);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        axw(REG_SAMPLE, {16'h0, v}, RESP_OKAY);
        axw(8'h0c, 32'h0, RESP_SLVERR);
        axr(8'h0c, 32'hffffffff, 32'h0, RESP_SLVERR);
        addr(OWN_ADDR_LO, 1'b1, 1'b1);
        m_bus.stop();
        repeat (150) @(posedge clk_sys);
        axr(REG_STATUS, 32'h3b, 32'h02, RESP_OKAY);
        addr(OWN_ADDR_LO, 1'b1, 1'b0);
        rd16(v);
        axr(REG_STATUS, 32'h1, 32'h1, RESP_OKAY);
        m_bus.stop();
        sync(8'ha0, 32'h31, 32'h11);
        repeat (450) @(posedge clk_sys);
        addr(GLOBAL_ADDR, 1'b0, 1'b0);
        m_bus.stop();
        axr(REG_STATUS, 32'h33, 32'h13, RESP_OKAY);
        sync(8'hd0, 32'h31, 32'h11);
        sync(8'h90, 32'h33, 32'h23);
        repeat (250) @(posedge clk_sys);
        axr(REG_STATUS, 32'hb, 32'h8, RESP_OKAY);
        address_select_pin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        addr(OWN_ADDR_HI, 1'b1, 1'b0);
        axr(REG_STATUS, 32'h6, 32'h2, RESP_OKAY);
        rd16(v);
        m_bus.stop();
        repeat (150) @(posedge clk_sys);
        axr(REG_STATUS, 32'h4, 32'h4, RESP_OKAY);
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        finish_test();
    end
endmodule
